// ===== hw/igs_pkg.sv
package igs_pkg;

  // ==========================================================
  // Interrupt vector layout
  // ==========================================================
  localparam int unsigned IRQ_W          = 32;
  localparam int unsigned BIT_RX_READY   = 0;
  localparam int unsigned BIT_RX_DISCARD = 1;
  localparam int unsigned BIT_TX_SENT    = 2;
  localparam int unsigned BIT_MAX_RETX   = 3;
  localparam int unsigned BIT_CRC_ERR    = 4;
  localparam int unsigned BIT_TXF_ERR    = 5;
  localparam int unsigned BIT_RXF_ERR    = 6;
  localparam int unsigned BIT_TXF_AFULL  = 7;
  localparam int unsigned BIT_TXF_AEMPTY = 8;
  localparam int unsigned BIT_RXF_AFULL  = 9;
  localparam int unsigned BIT_RXF_AEMPTY = 10;
  localparam int unsigned BIT_MAX_BACKOFF = 11;
  localparam int unsigned BIT_PREAMBLE   = 12;
  localparam int unsigned BIT_SYNC       = 13;
  localparam int unsigned BIT_CARRIER    = 14;
  localparam int unsigned BIT_WAKEUP     = 15;
  localparam int unsigned BIT_READY      = 16;
  localparam int unsigned BIT_STANDBY    = 17;
  localparam int unsigned BIT_LOW_BATT   = 18;
  localparam int unsigned BIT_POR        = 19;
  localparam int unsigned BIT_BROWNOUT   = 20;
  localparam int unsigned BIT_LOCK       = 21;
  localparam int unsigned BIT_RX_TIMEOUT = 29;
  localparam int unsigned BIT_CRYPTO_END = 30;
  // Bits with an event behind them; the rest read as zero
  localparam logic [31:0] IRQ_IMPL_MASK  = 32'h603f_ffff;
  localparam logic [31:0] IRQ_RESET      = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET     = 32'h0000_0000;

  // ==========================================================
  // Pin function selections
  // ==========================================================
  localparam int unsigned SEL_W = 5;
  localparam logic [4:0] OSEL_IRQ      = 5'h00;
  localparam logic [4:0] OSEL_VDD      = 5'h13;
  localparam logic [4:0] OSEL_GND      = 5'h14;
  localparam logic [4:0] ISEL_TX_CMD   = 5'h00;
  localparam logic [4:0] ISEL_RX_CMD   = 5'h01;
  localparam logic [4:0] ISEL_TX_DATA  = 5'h02;
  localparam logic [4:0] ISEL_WAKEUP   = 5'h03;
  localparam logic [4:0] ISEL_EXT_CLK  = 5'h04;
  localparam logic [4:0] CFG_SEL_RESET = 5'h14;

  // One pin's function configuration
  typedef struct packed {
    logic             drive_out;
    logic [SEL_W-1:0] sel;
  } igs_pin_cfg_t;

  // Internal signals routable to an output pin (selections 1..18 and 21..31)
  typedef struct packed {
    logic rc_cal_wait;
    logic synthesizer_full_en;
    logic vco_cal_wait;
    logic power_settle_wait;
    logic xo_ready_wait;
    logic lock_settle_wait;
    logic lock_detect_wait;
    logic lock_state;
    logic not_sleep_standby;
    logic sleep_standby;
    logic smps_enable;
    logic tx_or_rx;
    logic mcu_clk;
    logic carrier_sense;
    logic sync_det;
    logic preamble_valid;
    logic antenna_sel;
    logic rxf_aempty;
    logic rxf_afull;
    logic to_rx;
    logic rx_clk;
    logic rx_data;
    logic txf_afull;
    logic txf_aempty;
    logic to_tx;
    logic tx_clk;
    logic low_batt;
    logic wut_expired;
    logic por_n;
  } igs_route_t;

  // Decoded pin inputs
  typedef struct packed {
    logic tx_cmd;
    logic rx_cmd;
    logic tx_mod_data;
    logic ext_wakeup;
    logic ext_slow_clk;
  } igs_pin_in_t;

endpackage : igs_pkg

// ===== hw/igs_irq_gpio.sv
`timescale 1ns/1ps
module igs_irq_gpio #(
  parameter int unsigned NUM_PINS = 4
) (
  // Clock and reset
  input  wire logic                                  clk_i,
  input  wire logic                                  rst_b_i,
  // Event pulses and levels from the engines
  input  wire logic [igs_pkg::IRQ_W-1:0]             event_i,
  input  wire logic                                  wakeup_timer_end_i,
  input  wire logic                                  xo_clk_avail_i,
  input  wire logic                                  ready_state_i,
  input  wire logic                                  xo_settled_signal_i,
  // Status read and mask
  input  wire logic                                  status_rd_i,
  input  wire logic [igs_pkg::IRQ_W-1:0]             irq_mask_i,
  output logic      [igs_pkg::IRQ_W-1:0]             status_o,
  output logic      [igs_pkg::IRQ_W-1:0]             status_rd_data_o,
  output logic                                       irq_request_n_o,
  // Pin function configuration and routed signals
  input  wire igs_pkg::igs_pin_cfg_t [NUM_PINS-1:0]  pin_function_cfg_i,
  input  wire igs_pkg::igs_route_t                   route_i,
  // Pins, three signals each
  input  wire logic [NUM_PINS-1:0]                   pin_in_i,
  output logic      [NUM_PINS-1:0]                   pin_out_o,
  output logic      [NUM_PINS-1:0]                   pin_oe_o,
  // Functions taken from the pins
  output igs_pkg::igs_pin_in_t                       pin_func_o
);

  // ==========================================================
  // Elaboration checks
  // ==========================================================
  // Request and decode fan out to at most eight pins
  if (NUM_PINS < 1 || NUM_PINS > 8)
  begin : g_bad_pins
    $error("NUM_PINS must lie between 1 and 8");
  end

  // The source table and flag masks are written for a 32-bit vector
  if (igs_pkg::IRQ_W != 32)
  begin : g_bad_irq_w
    $error("IRQ_W must be 32");
  end

  // Five selection bits reach every entry of the 32-way table
  if (igs_pkg::SEL_W != 5)
  begin : g_bad_sel_w
    $error("SEL_W must be 5");
  end

  // One routed signal for every selection except 0, 19 and 20
  if ($bits(igs_pkg::igs_route_t) != 29)
  begin : g_bad_route
    $error("Route bundle must carry 29 signals");
  end

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [igs_pkg::IRQ_W-1:0] status;
    logic [igs_pkg::IRQ_W-1:0] rd_data;
    logic                      wut_pending;
    logic                      ready_seen;
    logic                      irq_active;
    logic [NUM_PINS-1:0]       pin_out;
    logic [NUM_PINS-1:0]       pin_oe;
    igs_pkg::igs_pin_in_t      func;
  } igs_state_t;

  localparam igs_state_t STATE_RESET = '{
    status      : igs_pkg::IRQ_RESET,
    rd_data     : igs_pkg::IRQ_RESET,
    wut_pending : 1'b0,
    ready_seen  : 1'b0,
    irq_active  : 1'b0,
    pin_out     : '0,
    pin_oe      : '0,
    func        : '0
  };

  igs_state_t state;
  igs_state_t next_state;

  logic [igs_pkg::IRQ_W-1:0] set_vec;
  logic [igs_pkg::IRQ_W-1:0] held_vec;
  logic [31:0]               out_src;
  logic                      ready_entry;
  logic                      wut_flag;

  // Per-pin results, one slot a pin
  logic [NUM_PINS-1:0]       pin_drive;
  logic [NUM_PINS-1:0]       pin_value;
  igs_pkg::igs_pin_in_t      pin_fn [NUM_PINS];

  // ==========================================================
  // Event capture
  // ==========================================================
  // Ready entry seen only once the crystal has settled
  assign ready_entry = ready_state_i & xo_settled_signal_i & ~state.ready_seen;

  // Wake-up flag deferred until the crystal clock is up
  // The raw timer end still reaches a pin through selection 2 at once
  assign wut_flag = (state.wut_pending | wakeup_timer_end_i) & xo_clk_avail_i;

  // Engine events mapped bit for bit; 15 and 16 come from local logic
  always_comb
  begin
    // Positions with no event behind them stay zero
    set_vec                          = '0;
    // Packet events
    set_vec[igs_pkg::BIT_RX_READY]    = event_i[igs_pkg::BIT_RX_READY];
    set_vec[igs_pkg::BIT_RX_DISCARD]  = event_i[igs_pkg::BIT_RX_DISCARD];
    set_vec[igs_pkg::BIT_TX_SENT]     = event_i[igs_pkg::BIT_TX_SENT];
    set_vec[igs_pkg::BIT_MAX_RETX]    = event_i[igs_pkg::BIT_MAX_RETX];
    set_vec[igs_pkg::BIT_CRC_ERR]     = event_i[igs_pkg::BIT_CRC_ERR];
    // FIFO errors and levels
    set_vec[igs_pkg::BIT_TXF_ERR]     = event_i[igs_pkg::BIT_TXF_ERR];
    set_vec[igs_pkg::BIT_RXF_ERR]     = event_i[igs_pkg::BIT_RXF_ERR];
    set_vec[igs_pkg::BIT_TXF_AFULL]   = event_i[igs_pkg::BIT_TXF_AFULL];
    set_vec[igs_pkg::BIT_TXF_AEMPTY]  = event_i[igs_pkg::BIT_TXF_AEMPTY];
    set_vec[igs_pkg::BIT_RXF_AFULL]   = event_i[igs_pkg::BIT_RXF_AFULL];
    set_vec[igs_pkg::BIT_RXF_AEMPTY]  = event_i[igs_pkg::BIT_RXF_AEMPTY];
    // Channel access
    set_vec[igs_pkg::BIT_MAX_BACKOFF] = event_i[igs_pkg::BIT_MAX_BACKOFF];
    // Signal quality
    set_vec[igs_pkg::BIT_PREAMBLE]    = event_i[igs_pkg::BIT_PREAMBLE];
    set_vec[igs_pkg::BIT_SYNC]        = event_i[igs_pkg::BIT_SYNC];
    set_vec[igs_pkg::BIT_CARRIER]     = event_i[igs_pkg::BIT_CARRIER];
    // Device status; wake-up and ready have their own capture
    set_vec[igs_pkg::BIT_WAKEUP]      = wut_flag;
    set_vec[igs_pkg::BIT_READY]       = ready_entry;
    set_vec[igs_pkg::BIT_STANDBY]     = event_i[igs_pkg::BIT_STANDBY];
    set_vec[igs_pkg::BIT_LOW_BATT]    = event_i[igs_pkg::BIT_LOW_BATT];
    set_vec[igs_pkg::BIT_POR]         = event_i[igs_pkg::BIT_POR];
    set_vec[igs_pkg::BIT_BROWNOUT]    = event_i[igs_pkg::BIT_BROWNOUT];
    set_vec[igs_pkg::BIT_LOCK]        = event_i[igs_pkg::BIT_LOCK];
    // Timer and crypto
    set_vec[igs_pkg::BIT_RX_TIMEOUT]  = event_i[igs_pkg::BIT_RX_TIMEOUT];
    set_vec[igs_pkg::BIT_CRYPTO_END]  = event_i[igs_pkg::BIT_CRYPTO_END];
  end

  // Flags stay set until a read; a new event in the read cycle survives
  assign held_vec = status_rd_i ? '0 : state.status;

  // ==========================================================
  // Output source table, index is the selection code
  // ==========================================================
  // Request is registered, so a pin lags the flag by one cycle
  always_comb
  begin
    out_src     = '0;
    out_src[igs_pkg::OSEL_IRQ] = ~state.irq_active;
    // Power, timer and transmit path
    out_src[1]  = route_i.por_n;
    out_src[2]  = route_i.wut_expired;
    out_src[3]  = route_i.low_batt;
    out_src[4]  = route_i.tx_clk;
    out_src[5]  = route_i.to_tx;
    // FIFO levels and receive path
    out_src[6]  = route_i.txf_aempty;
    out_src[7]  = route_i.txf_afull;
    out_src[8]  = route_i.rx_data;
    out_src[9]  = route_i.rx_clk;
    out_src[10] = route_i.to_rx;
    out_src[11] = route_i.rxf_afull;
    out_src[12] = route_i.rxf_aempty;
    // Link quality, clocks and front end
    out_src[13] = route_i.antenna_sel;
    out_src[14] = route_i.preamble_valid;
    out_src[15] = route_i.sync_det;
    out_src[16] = route_i.carrier_sense;
    out_src[17] = route_i.mcu_clk;
    out_src[18] = route_i.tx_or_rx;
    // Fixed levels for software-driven pins
    out_src[igs_pkg::OSEL_VDD] = 1'b1;
    out_src[igs_pkg::OSEL_GND] = 1'b0;
    // Power state indicators
    out_src[21] = route_i.smps_enable;
    out_src[22] = route_i.sleep_standby;
    out_src[23] = route_i.not_sleep_standby;
    // Sequencer conditions
    out_src[24] = route_i.lock_state;
    out_src[25] = route_i.lock_detect_wait;
    out_src[26] = route_i.lock_settle_wait;
    out_src[27] = route_i.xo_ready_wait;
    out_src[28] = route_i.power_settle_wait;
    out_src[29] = route_i.vco_cal_wait;
    out_src[30] = route_i.synthesizer_full_en;
    out_src[31] = route_i.rc_cal_wait;
  end

  // ==========================================================
  // Per-pin decode
  // ==========================================================
  // Each pin sees only its own configuration
  for (genvar p = 0; p < NUM_PINS; p++)
  begin : g_pin
    // Direction and level straight from the pin's own setting
    assign pin_drive[p] = pin_function_cfg_i[p].drive_out;
    assign pin_value[p] = pin_function_cfg_i[p].drive_out & out_src[pin_function_cfg_i[p].sel];

    // Input function; an output pin feeds none, so no loop back
    always_comb
    begin
      pin_fn[p] = '0;
      if (!pin_function_cfg_i[p].drive_out)
      begin
        case (pin_function_cfg_i[p].sel)
          igs_pkg::ISEL_TX_CMD:  pin_fn[p].tx_cmd       = pin_in_i[p];
          igs_pkg::ISEL_RX_CMD:  pin_fn[p].rx_cmd       = pin_in_i[p];
          igs_pkg::ISEL_TX_DATA: pin_fn[p].tx_mod_data  = pin_in_i[p];
          igs_pkg::ISEL_WAKEUP:  pin_fn[p].ext_wakeup   = pin_in_i[p];
          igs_pkg::ISEL_EXT_CLK: pin_fn[p].ext_slow_clk = pin_in_i[p];
          // Selections 5 and up are accepted and ignored
          default:               pin_fn[p]              = '0;
        endcase
      end
    end
  end

  // ==========================================================
  // Next state
  // ==========================================================
  // Whole next state built here, registered below
  always_comb
  begin
    next_state = state;

    // Set wins over the read clear
    // so an event in the read cycle is never lost
    next_state.status = held_vec | set_vec;
    next_state.rd_data = status_rd_i ? state.status : state.rd_data;

    // Timer end remembered until the crystal clock comes up
    next_state.wut_pending = (state.wut_pending | wakeup_timer_end_i) & ~xo_clk_avail_i;
    next_state.ready_seen = ready_state_i & xo_settled_signal_i;

    // Combined request from unmasked flags after this cycle
    // A late enable still raises the request for a held flag
    next_state.irq_active = |(next_state.status & irq_mask_i);

    // Pin results gathered; one input selection on two pins is ORed
    next_state.pin_oe  = pin_drive;
    next_state.pin_out = pin_value;
    next_state.func    = '0;
    for (int p = 0; p < NUM_PINS; p++)
    begin
      next_state.func = igs_pkg::igs_pin_in_t'(next_state.func | pin_fn[p]);
    end
  end

  // ==========================================================
  // Register
  // ==========================================================
  // One register for the whole state; reset clears every flag
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state <= STATE_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // Every output comes straight from a flip-flop, the request through an inverter
  assign status_o         = state.status;
  assign status_rd_data_o = state.rd_data;
  assign irq_request_n_o  = ~state.irq_active;
  assign pin_out_o        = state.pin_out;
  assign pin_oe_o         = state.pin_oe;
  assign pin_func_o       = state.func;

endmodule : igs_irq_gpio

// ===== tb/igs_irq_gpio_properties.sv
`timescale 1ns/1ps
// ==========================================
// Interrupt and pin function checker
module igs_irq_gpio_properties #(
  parameter int unsigned NUM_PINS = 4
) (
  // Clock, reset, event sources
  input wire logic                                 clk_i,
  input wire logic                                 rst_b_i,
  input wire logic [31:0]                          event_i,
  input wire logic                                 xo_clk_avail_i,
  input wire logic                                 ready_state_i,
  input wire logic                                 xo_settled_signal_i,
  // Status side
  input wire logic                                 status_rd_i,
  input wire logic [31:0]                          irq_mask_i,
  input wire logic [31:0]                          status_o,
  input wire logic [31:0]                          status_rd_data_o,
  input wire logic                                 irq_request_n_o,
  // Pins
  input wire igs_pkg::igs_pin_cfg_t [NUM_PINS-1:0] pin_function_cfg_i,
  input wire igs_pkg::igs_route_t                  route_i,
  input wire logic [NUM_PINS-1:0]                  pin_in_i,
  input wire logic [NUM_PINS-1:0]                  pin_out_o,
  input wire logic [NUM_PINS-1:0]                  pin_oe_o,
  input wire igs_pkg::igs_pin_in_t                 pin_func_o
);
  // Flags set straight from event_i; 15 and 16 have their own sources
  localparam logic [31:0] SET_M = 32'h603e_7fff;
  logic [NUM_PINS-1:0] drv;
  logic [4:0]          fexp;
  logic [4:0]          rsel;
  logic                rbit;
  // Expected input decode; selections from 5 upward are dead
  always_comb
  begin
    fexp = 5'h00;
    for (int k = 0; k < NUM_PINS; k++)
    begin
      drv[k] = pin_function_cfg_i[k].drive_out;
      if (!drv[k] && pin_function_cfg_i[k].sel < 5'h05)
        fexp = fexp | ((5'h10 >> pin_function_cfg_i[k].sel) & {5{pin_in_i[k]}});
    end
  end
  // Route index skips the two constant selections
  assign rsel = pin_function_cfg_i[1].sel;
  assign rbit = route_i[(rsel < 5'h13) ? rsel - 5'h01 : rsel - 5'h03];
  // ==========================================
  // Properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_event_flag: assert property ((event_i & SET_M) != 32'h0 |=>
    (status_o & $past(event_i) & SET_M) == ($past(event_i) & SET_M)) else $error("event flag not set");
  a_unimpl_zero: assert property ((status_o & ~igs_pkg::IRQ_IMPL_MASK) == 32'h0)
    else $error("unimplemented flag set");
  a_read_snap: assert property (status_rd_i |=> status_rd_data_o == $past(status_o))
    else $error("read data not the pre-read flags");
  a_read_clear: assert property (status_rd_i && !xo_clk_avail_i && !ready_state_i |=>
    status_o == ($past(event_i) & SET_M)) else $error("read did not clear flags");
  a_irq_combine: assert property (irq_request_n_o == !(|(status_o & $past(irq_mask_i))))
    else $error("request does not match enabled flags");
  a_irq_pin: assert property (drv[0] && pin_function_cfg_i[0].sel == 5'h00 |=>
    pin_out_o[0] == $past(irq_request_n_o)) else $error("pin 0 not showing request");
  a_const_level: assert property (drv[1] && (rsel == 5'h13 || rsel == 5'h14) |=>
    pin_oe_o[1] && pin_out_o[1] == $past(rsel == 5'h13)) else $error("constant level wrong");
  a_route_sel: assert property (drv[1] && rsel != 5'h00 && rsel != 5'h13 && rsel != 5'h14 |=>
    pin_out_o[1] == $past(rbit)) else $error("routed signal wrong");
  a_pin_dir: assert property (1'b1 |=> pin_oe_o == $past(drv) && (pin_out_o & ~pin_oe_o) == '0)
    else $error("pin direction wrong");
  a_input_func: assert property (1'b1 |=> pin_func_o == $past(fexp))
    else $error("input function wrong");
  a_wake_wait: assert property (!xo_clk_avail_i |=> !$rose(status_o[15]))
    else $error("wake flag set without crystal");
  a_ready_flag: assert property ($rose(ready_state_i && xo_settled_signal_i) |=> status_o[16])
    else $error("ready flag not set");
  c_read: cover property (status_rd_i && status_o != 32'h0);
  c_irq: cover property (!irq_request_n_o);
  c_func: cover property (pin_func_o != '0);
endmodule : igs_irq_gpio_properties

bind igs_irq_gpio igs_irq_gpio_properties #(.NUM_PINS(NUM_PINS)) i_props (.clk_i, .rst_b_i, .event_i,
  .xo_clk_avail_i, .ready_state_i, .xo_settled_signal_i, .status_rd_i, .irq_mask_i, .status_o,
  .status_rd_data_o, .irq_request_n_o, .pin_function_cfg_i, .route_i, .pin_in_i, .pin_out_o, .pin_oe_o, .pin_func_o);

// ===== tb/igs_host_model.sv
`timescale 1ns/1ps
// ==========================================
// Host side of the pins
module igs_host_model #(
  parameter int unsigned NUM_PINS = 4
) (
  // Device drivers
  input  wire logic [NUM_PINS-1:0] pin_out_i,
  input  wire logic [NUM_PINS-1:0] pin_oe_i,
  // Host levels and resolved wire
  input  wire logic [NUM_PINS-1:0] host_lvl_i,
  output logic      [NUM_PINS-1:0] pin_lvl_o
);
  // Host drives only pins left free, so it never fights the device
  assign pin_lvl_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & host_lvl_i);
endmodule : igs_host_model

// ===== tb/tb_top.sv
`timescale 1ns/1ps
// ==========================================
// Bench for flag aggregation and pin functions
module tb_top;
  localparam int unsigned NP = 4;
  // Flag table row: events, enables, expected flags, expected request
  typedef struct packed {
    logic [31:0] ev;
    logic [31:0] mask;
    logic [31:0] st;
    logic        irq_n;
  } igs_row_t;
  logic                           clk_i = 1'b0;
  logic                           rst_b_i, wakeup_timer_end_i, xo_clk_avail_i, ready_state_i, xo_settled_signal_i;
  logic                           status_rd_i, irq_request_n_o;
  logic [31:0]                    event_i, irq_mask_i, status_o, status_rd_data_o;
  igs_pkg::igs_pin_cfg_t [NP-1:0] pin_function_cfg_i;
  igs_pkg::igs_route_t            route_i;
  logic [NP-1:0]                  pin_in_i, pin_out_o, pin_oe_o, host_lvl;
  igs_pkg::igs_pin_in_t           pin_func_o;
  int                             miscompares = 0;
  int                             compares = 0;
  igs_row_t rows [6] = '{'{32'h0000_001f, 32'hffff_ffff, 32'h0000_001f, 1'b0},
    '{32'h0000_07e0, 32'h0000_0040, 32'h0000_07e0, 1'b0}, '{32'h0000_0800, 32'h0000_0000, 32'h0000_0800, 1'b1},
    '{32'h0000_7000, 32'h0000_4000, 32'h0000_7000, 1'b0}, '{32'h603e_0000, 32'h2000_0000, 32'h603e_0000, 1'b0},
    '{32'hffff_ffff, 32'h9fc1_8000, 32'h603e_7fff, 1'b1}};
  igs_irq_gpio #(.NUM_PINS(NP)) i_dut (.clk_i, .rst_b_i, .event_i, .wakeup_timer_end_i, .xo_clk_avail_i,
    .ready_state_i, .xo_settled_signal_i, .status_rd_i, .irq_mask_i, .status_o, .status_rd_data_o,
    .irq_request_n_o, .pin_function_cfg_i, .route_i, .pin_in_i, .pin_out_o, .pin_oe_o, .pin_func_o);
  igs_host_model #(.NUM_PINS(NP)) i_host (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .host_lvl_i(host_lvl),
    .pin_lvl_o(pin_in_i));
  // 100 ns clock
  initial forever #50 clk_i = ~clk_i;
  // ==========================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc
  task automatic rd();
    status_rd_i = 1'b1;
    cyc(1);
    status_rd_i = 1'b0;
  endtask : rd
  task automatic results();
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  // Watchdog: the sequence is far shorter than this
  initial
  begin
    repeat (3000) @(posedge clk_i);
    miscompares++;
    results();
  end
  // ==========================================
  // Main sequence; inputs change just after falling edges
  initial
  begin
    {rst_b_i, wakeup_timer_end_i, xo_clk_avail_i, ready_state_i, xo_settled_signal_i, status_rd_i} = 6'h00;
    event_i = 32'h0;
    irq_mask_i = 32'h0;
    route_i = '0;
    host_lvl = 4'h0;
    pin_function_cfg_i = {6'h14, 6'h14, 6'h33, 6'h20};
    cyc(13);
    chk(irq_request_n_o, 1'b1);
    chk(status_o | pin_oe_o, 32'h0);
    rst_b_i = 1'b1;
    cyc(2);
    foreach (rows[i])
    begin
      event_i = rows[i].ev;
      irq_mask_i = rows[i].mask;
      cyc(1);
      event_i = 32'h0;
      cyc(1);
      chk(status_o, rows[i].st);
      chk(irq_request_n_o, rows[i].irq_n);
      rd();
      cyc(1);
      chk(status_rd_data_o, rows[i].st);
      chk({status_o[30:0], irq_request_n_o}, 32'h1);
    end
    // Read meets a new event: the new event must survive the clear
    irq_mask_i = 32'h5;
    event_i = 32'h1;
    cyc(1);
    event_i = 32'h4;
    status_rd_i = 1'b1;
    cyc(1);
    event_i = 32'h0;
    status_rd_i = 1'b0;
    cyc(1);
    chk(status_rd_data_o, 32'h1);
    chk(status_o, 32'h4);
    chk(pin_out_o[0], 1'b0);
    rd();
    cyc(2);
    chk(pin_out_o[0], 1'b1);
    // Enable arriving after the flag
    irq_mask_i = 32'h0;
    event_i = 32'h8;
    cyc(1);
    event_i = 32'h0;
    cyc(1);
    chk(irq_request_n_o, 1'b1);
    irq_mask_i = 32'h8;
    cyc(2);
    chk(irq_request_n_o, 1'b0);
    rd();
    cyc(1);
    // Wake flag waits for the crystal clock
    wakeup_timer_end_i = 1'b1;
    cyc(1);
    wakeup_timer_end_i = 1'b0;
    cyc(3);
    chk(status_o[15], 1'b0);
    xo_clk_avail_i = 1'b1;
    cyc(2);
    chk(status_o[15], 1'b1);
    rd();
    // Ready flag only on a settled entry
    ready_state_i = 1'b1;
    cyc(2);
    chk(status_o[16], 1'b0);
    xo_settled_signal_i = 1'b1;
    cyc(2);
    chk(status_o[16], 1'b1);
    rd();
    cyc(2);
    chk(status_o[16], 1'b0);
    ready_state_i = 1'b0;
    cyc(1);
    ready_state_i = 1'b1;
    cyc(2);
    chk(status_o[16], 1'b1);
    rd();
    // Output selections 1 to 31 on pin 1, one-hot and inverted sources
    for (int s = 1; s < 32; s++)
    begin
      pin_function_cfg_i[1] = {1'b1, 5'(s)};
      for (int v = 0; v < 2; v++)
      begin
        route_i = igs_pkg::igs_route_t'(29'h1 << ((s < 19) ? s - 1 : s - 3));
        if (v == 1)
          route_i = ~route_i;
        cyc(1);
        chk({pin_oe_o[1], pin_out_o[1]}, (s == 19) ? 2'h3 : (s == 20) ? 2'h2 : 2'(3 - v));
      end
    end
    // Input selections on pin 3; pin 2 held high on a dead selection
    host_lvl = 4'hc;
    for (int s = 0; s < 8; s++)
    begin
      pin_function_cfg_i[3] = {1'b0, 5'(s)};
      cyc(2);
      chk({pin_oe_o[3], pin_func_o}, (s < 5) ? 6'h10 >> s : 6'h00);
    end
    // Reset in mid-run with a flag held and ready still high
    event_i = 32'h1;
    cyc(1);
    event_i = 32'h0;
    rst_b_i = 1'b0;
    cyc(2);
    chk({status_o[30:0], irq_request_n_o}, 32'h1);
    chk(pin_oe_o, 4'h0);
    rst_b_i = 1'b1;
    cyc(2);
    chk(status_o, 32'h0001_0000);
    rd();
    results();
  end
endmodule : tb_top
